// File: srt_pkg.sv
// Functional notes
// - Reset output is driven low while the supply or the adjustable sense input reports undervoltage.
// - After all supplies recover, reset stays low for the 210 ms timeout and then goes high.
// - A valid long press yields one low pulse of one reset timeout period, at least 140 ms.
// - In single-button mode the button must stay low for 6.72 s before a pulse; shorter presses are ignored.
// - In dual-button mode both buttons must stay low together for 6.72 s before a pulse.
// - In immediate mode a rising level on the second input starts a timeout pulse at once.
// - Only one pulse per long press; a button must go high and be held low again for another.
// - A new rising edge on the immediate input during the pulse restarts the full timeout.
// - A falling level on the immediate input is debounced for 210 ms and never causes a pulse.
package srt_pkg;
	localparam int unsigned CLK_HZ         = 125_000_000;
	localparam int unsigned TIMEOUT_MS     = 210;
	localparam int unsigned SETUP_MS       = 6720;
	localparam longint unsigned TIMEOUT_CYC =
		longint'(CLK_HZ) * TIMEOUT_MS / 1000;
	localparam longint unsigned SETUP_CYC =
		longint'(CLK_HZ) * SETUP_MS / 1000;
	localparam int unsigned CNT_W = 30;

	typedef enum logic [1:0] {
		SRT_MODE_SINGLE = 2'h0,
		SRT_MODE_DUAL   = 2'h1,
		SRT_MODE_IMMED  = 2'h2
	} srt_mode_e;

	typedef enum logic [1:0] {
		SRT_ST_UV    = 2'h0,
		SRT_ST_HOLD  = 2'h1,
		SRT_ST_RUN   = 2'h2,
		SRT_ST_PULSE = 2'h3
	} srt_state_e;

	typedef struct packed {
		logic supply_low;
		logic sense_low;
		logic button_n;
		logic second;
	} srt_in_s;
endpackage

// File: srt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module srt_sync (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic d_i,
	input  wire logic init_i,
	output logic      q_o
);
	logic [2:0] sh_r;
	logic [2:0] sh_nxt;
	logic       q_r;
	logic       q_nxt;

	// Stage one is only ever read by stage two.
	always_comb begin
		sh_nxt = {sh_r[1:0], d_i};
		q_nxt  = (sh_r[1] == sh_r[2]) ? sh_r[2] : q_r;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sh_r <= {3{init_i}};
			q_r  <= init_i;
		end else begin
			sh_r <= sh_nxt;
			q_r  <= q_nxt;
		end
	end

	// The reset level stands in for the pin until the chain has filled.
	assign q_o = q_r;
endmodule
`default_nettype wire

// File: srt_core.sv
`timescale 1ns/1ps
`default_nettype none
module srt_core #(
	parameter srt_pkg::srt_mode_e MODE = srt_pkg::SRT_MODE_SINGLE,
	parameter longint unsigned TIMEOUT_CYC = srt_pkg::TIMEOUT_CYC,
	parameter longint unsigned SETUP_CYC   = srt_pkg::SETUP_CYC
) (
	input  wire logic            clk_i,
	input  wire logic            rst_n_i,
	input  wire srt_pkg::srt_in_s in_i,
	output logic                 reset_n_o
);
	localparam int W = srt_pkg::CNT_W;
	// Counters end one short of the count, since zero is their first cycle.
	localparam logic [W-1:0] TO_LAST = W'(TIMEOUT_CYC - 1);
	localparam logic [W-1:0] SU_LAST = W'(SETUP_CYC - 1);

	// All three timers share these helpers, so none can end a cycle
	// early through a compare written differently from the others.
	function automatic logic [W-1:0] cnt_inc(input logic [W-1:0] c);
		return c + W'(1);
	endfunction

	function automatic logic cnt_done(
		input logic [W-1:0] c,
		input logic [W-1:0] last
	);
		return c == last;
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic supply_low;
	logic sense_low;
	logic button_n;
	logic second;

	// Supplies read as low until the chain has seen them good, so the
	// recovery timeout never starts from an unfilled synchroniser.
	srt_sync u_sup (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.d_i    (in_i.supply_low),
		.init_i (1'h1),
		.q_o    (supply_low)
	);

	srt_sync u_sen (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.d_i    (in_i.sense_low),
		.init_i (1'h1),
		.q_o    (sense_low)
	);

	// The button reads as pressed until seen released, so a button held
	// through power-up is never armed.
	srt_sync u_btn (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.d_i    (~in_i.button_n),
		.init_i (1'h1),
		.q_o    (button_n)
	);

	// Idle low suits the immediate input; a rise seen just after reset
	// only restarts the recovery timeout that is running anyway.
	srt_sync u_sec (
		.clk_i  (clk_i),
		.rst_n_i(rst_n_i),
		.d_i    (in_i.second),
		.init_i (1'h0),
		.q_o    (second)
	);

	////////////////////////////////////////////////////////////////////////
	// button_n carries the inverted pin, so high means pressed here.
	logic press;
	logic uv;
	always_comb begin
		uv = supply_low | sense_low;
		// In dual mode the second pin is a button, so low means pressed.
		case (MODE)
			srt_pkg::SRT_MODE_DUAL:  press = button_n & ~second;
			default:                 press = button_n;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Immediate input: rise acts at once, fall is debounced and ignored.
	logic          sec_lvl_r;
	logic          sec_lvl_nxt;
	logic [W-1:0]  db_r;
	logic [W-1:0]  db_nxt;
	logic          rise;
	always_comb begin
		sec_lvl_nxt = sec_lvl_r;
		db_nxt      = '0;
		rise        = 1'h0;
		if (MODE == srt_pkg::SRT_MODE_IMMED) begin
			if (second && !sec_lvl_r) begin
				rise        = 1'h1;
				sec_lvl_nxt = 1'h1;
			end else if (!second && sec_lvl_r) begin
				// A rise while this runs is no new event: the pin never settled.
				db_nxt = cnt_inc(db_r);
				if (cnt_done(db_r, TO_LAST)) begin
					sec_lvl_nxt = 1'h0;
					db_nxt      = '0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sec_lvl_r <= 1'h0;
			db_r      <= '0;
		end else begin
			sec_lvl_r <= sec_lvl_nxt;
			db_r      <= db_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Long-press timer; armed only after the press is released.
	logic         armed_r;
	logic         armed_nxt;
	logic [W-1:0] su_r;
	logic [W-1:0] su_nxt;
	logic         long_fire;
	always_comb begin
		armed_nxt = armed_r;
		su_nxt    = '0;
		long_fire = 1'h0;
		// Release re-arms; only a full fresh press may fire again.
		if (!press) begin
			armed_nxt = 1'h1;
		end else if (armed_r) begin
			su_nxt = cnt_inc(su_r);
			if (cnt_done(su_r, SU_LAST)) begin
				long_fire = 1'h1;
				armed_nxt = 1'h0;
				su_nxt    = '0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			// Not armed: a button already held at power-up needs release.
			armed_r <= 1'h0;
			su_r    <= '0;
		end else begin
			armed_r <= armed_nxt;
			su_r    <= su_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	srt_pkg::srt_state_e st_r;
	srt_pkg::srt_state_e st_nxt;
	logic [W-1:0]        to_r;
	logic [W-1:0]        to_nxt;
	logic                rst_out_r;
	logic                rst_out_nxt;
	always_comb begin
		st_nxt      = st_r;
		to_nxt      = to_r;
		// Reset stays low unless a branch below lets it go.
		rst_out_nxt = 1'h0;
		case (st_r)
			srt_pkg::SRT_ST_UV: begin
				to_nxt = '0;
				if (!uv)
					st_nxt = srt_pkg::SRT_ST_HOLD;
			end
			// Recovery hold and manual pulse share one timeout counter.
			srt_pkg::SRT_ST_HOLD, srt_pkg::SRT_ST_PULSE: begin
				to_nxt = cnt_inc(to_r);
				if (rise)
					to_nxt = '0;
				else if (cnt_done(to_r, TO_LAST)) begin
					to_nxt      = '0;
					st_nxt      = srt_pkg::SRT_ST_RUN;
					rst_out_nxt = 1'h1;
				end
			end
			srt_pkg::SRT_ST_RUN: begin
				// Long press and immediate rise share one pulse path.
				rst_out_nxt = 1'h1;
				if (long_fire || rise) begin
					st_nxt      = srt_pkg::SRT_ST_PULSE;
					rst_out_nxt = 1'h0;
				end
			end
			default: st_nxt = srt_pkg::SRT_ST_UV;
		endcase
		// Undervoltage overrides every state, a running pulse included.
		if (uv) begin
			st_nxt      = srt_pkg::SRT_ST_UV;
			to_nxt      = '0;
			rst_out_nxt = 1'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_r      <= srt_pkg::SRT_ST_UV;
			to_r      <= '0;
			rst_out_r <= 1'h0;
		end else begin
			st_r      <= st_nxt;
			to_r      <= to_nxt;
			rst_out_r <= rst_out_nxt;
		end
	end

	// The pin comes straight from its register, so no decode glitch can
	// reach the processor.
	assign reset_n_o = rst_out_r;
endmodule
`default_nettype wire

// File: srt_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module srt_chk #(
	parameter srt_pkg::srt_mode_e MODE        = srt_pkg::SRT_MODE_SINGLE,
	parameter longint unsigned    TIMEOUT_CYC = 20,
	parameter longint unsigned    SETUP_CYC   = 50
) (
	input wire logic             clk_i,
	input wire logic             rst_n_i,
	input wire srt_pkg::srt_in_s in_i,
	input wire logic             reset_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire imm = MODE == srt_pkg::SRT_MODE_IMMED;
	wire uv  = in_i.supply_low | in_i.sense_low;
	wire prs = !in_i.button_n && (MODE != srt_pkg::SRT_MODE_DUAL || !in_i.second);
	logic [31:0] lo, pr, sr, sl, qt, ul;
	logic [1:0]  nf;
	// Run lengths let each timing figure be checked at the ports, as a bound with a few cycles of slack.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			{lo, pr, sr, sl, qt, ul} <= '0;
			nf <= 2'h0;
		end else begin
			lo <= reset_n_o ? 32'h0 : lo + 32'h1;
			pr <= prs ? pr + 32'h1 : 32'h0;
			sr <= $rose(in_i.second) ? 32'h0 : sr + 32'h1;
			sl <= in_i.second ? 32'h0 : sl + 32'h1;
			qt <= (uv | !in_i.button_n | $changed(in_i.second)) ? 32'h0 : qt + 32'h1;
			ul <= uv ? 32'h0 : ul + 32'h1;
			nf <= prs ? nf + {1'b0, $fell(reset_n_o)} : 2'h0;
		end
	end
	sequence s_arm;
		imm && sl > TIMEOUT_CYC + 8 ##0 $rose(in_i.second);
	endsequence
	AST_UV_LOW: assert property (uv [*8] |-> !reset_n_o)
		else $error("reset high in undervoltage");
	AST_MIN_LOW: assert property ($rose(reset_n_o) |-> lo >= TIMEOUT_CYC)
		else $error("reset low too short");
	AST_RELEASE: assert property (qt == TIMEOUT_CYC + 16 |-> reset_n_o)
		else $error("reset not released");
	AST_ONE_PULSE: assert property (imm || nf < 2'h2)
		else $error("second pulse in one press");
	AST_PRESS_LEN: assert property ($fell(reset_n_o) && ul > 8 && !(imm && sr < 8) |-> pr >= SETUP_CYC)
		else $error("pulse without full press");
	AST_IMM_FAST: assert property (s_arm |-> ##[1:8] !reset_n_o)
		else $error("no pulse on rise");
	AST_IMM_RESTART: assert property (imm && $rose(reset_n_o) |-> sr >= TIMEOUT_CYC)
		else $error("pulse ended early after rise");
	AST_FALL_IGNORED: assert property (imm && reset_n_o && in_i.button_n && ul > 8 && $fell(in_i.second) |-> reset_n_o [*8])
		else $error("pulse on falling input");
endmodule
bind srt_core srt_chk #(.MODE(MODE), .TIMEOUT_CYC(TIMEOUT_CYC),
	.SETUP_CYC(SETUP_CYC)) srt_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.in_i(in_i), .reset_n_o(reset_n_o));
`default_nettype wire

// File: srt_cpu.sv
`timescale 1ns/1ps
`default_nettype none
// Processor reset pin: counts finished reset periods and their length.
module srt_cpu (
	input  wire logic   clk_i,
	input  wire logic   reset_n_i,
	output logic [7:0]  boots_o,
	output logic [15:0] len_o
);
	logic [7:0]  boots_r = 8'h0;
	logic [15:0] len_r   = 16'h0;
	logic [15:0] run     = 16'h0;
	always @(posedge clk_i) begin
		if (!reset_n_i) begin
			run <= run + 16'h1;
		end else if (run != 16'h0) begin
			boots_r <= boots_r + 8'h1;
			len_r   <= run;
			run     <= 16'h0;
		end
	end
	assign boots_o = boots_r;
	assign len_o   = len_r;
endmodule
`default_nettype wire

// File: srt_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module srt_core_tb_top;
	localparam int unsigned TO = 20;
	localparam int unsigned SU = 50;
	localparam logic [3:0] TBL [11] = '{4'h0, 4'h3, 4'h1, 4'h3, 4'h2, 4'h0,
		4'h2, 4'ha, 4'h2, 4'h6, 4'h2};
	logic             clk_i = 1'b0;
	logic             rst_n_i = 1'b0;
	srt_pkg::srt_in_s in_r = 4'h2;
	wire [2:0]        rn;
	wire [7:0]        boots [3];
	wire [15:0]       len [3];
	int               failures = 0;
	int               compares = 0;
	int               want [3] = '{1, 1, 1};
	int               hit [3];
	always #4 clk_i = ~clk_i;
	for (genvar g = 0; g < 3; g++) begin : gm
		srt_core #(.MODE(srt_pkg::srt_mode_e'(g)), .TIMEOUT_CYC(TO),
			.SETUP_CYC(SU)) srt_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
			.in_i(in_r), .reset_n_o(rn[g]));
		srt_cpu srt_cpu_i (.clk_i(clk_i), .reset_n_i(rn[g]),
			.boots_o(boots[g]), .len_o(len[g]));
	end
	function automatic logic fires(int m, logic [3:0] p, logic [3:0] v);
		if (!v[1])
			return m != 1 || !v[0];
		return m == 2 && !p[0] && v[0];
	endfunction
	task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
		compares++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %0d seen %0d", n, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic drive(input logic [3:0] v, input int n);
		@(posedge clk_i);
		in_r <= v;
		repeat (n) @(negedge clk_i);
	endtask
	task automatic settle();
		int i;
		for (i = 0; i < 500 && rn !== 3'h7; i++) @(negedge clk_i);
		if (i == 500) begin
			failures++;
			end_of_test();
		end
		repeat (3) @(negedge clk_i);
		for (int m = 0; m < 3; m++)
			chk(16'(boots[m]), 16'(want[m]), "resets");
	endtask
	initial begin
		logic [3:0] p;
		int n;
		p = 4'h2;
		void'($urandom(43993));
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		settle();
		// A short press comes first so that a wrongly armed timer shows later.
		for (int k = 0; k < 11; k++) begin
			n = k == 0 ? $urandom_range(SU - 10, 2) : TBL[k][1] ? int'(TO) + 30
				: $urandom_range(3 * SU, 2 * SU + 5);
			drive(TBL[k], n);
			for (int m = 0; m < 3; m++) begin
				hit[m] = k > 0 && fires(m, p, TBL[k]);
				want[m] += hit[m] + int'(TBL[k][3] | TBL[k][2]);
			end
			if (TBL[k][3] | TBL[k][2]) begin
				chk(16'(rn), 16'h0, "reset in uv");
			end else begin
				settle();
				for (int m = 0; m < 3; m++)
					if (hit[m]) chk(len[m], 16'(TO), "pulse");
			end
			p = TBL[k];
		end
		// Corner case: a rise on the immediate input in the middle of a
		// long-press pulse stretches that pulse in immediate mode only.
		drive(4'h0, int'(SU) + 10);
		drive(4'h1, int'(TO) + 30);
		drive(4'h3, int'(TO) + 30);
		for (int m = 0; m < 3; m++)
			want[m] += 1;
		settle();
		for (int m = 0; m < 3; m++)
			chk(16'(len[m] > 16'(TO)), 16'(m == 2), "restart");
		end_of_test();
	end
endmodule
`default_nettype wire
